/* File: verilog/stp_pkg.sv */
// scan test port constants: tap states, instruction codes, register widths
// assumes a single test access port with a small private instruction set
package stp_pkg;
	// ==========================================================
	// tap controller states
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
		ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR,
		ST_EX2_IR, ST_UPD_IR
	} stp_state_e;
	// ==========================================================
	// instruction register
	localparam int IR_W = 4;
	localparam logic [3:0] IR_RESET_VAL = 4'h1;  // idcode-like default select
	localparam logic [1:0] IR_CAPTURE_VAL = 2'h1; // low bits captured into ir
	localparam logic [3:0] OP_BYPASS = 4'hF;
	localparam logic [3:0] OP_IDCODE = 4'h1;
	localparam logic [3:0] OP_EMUCTL = 4'h2;
	// ==========================================================
	// data registers
	localparam int ID_W = 32;
	localparam int EMU_W = 2;  // bit0 line zero output enable, bit1 line one
	localparam logic [1:0] EMU_RESET_VAL = 2'h0;
	// value is arbitrary, not any real maker or part
	localparam logic [31:0] ID_DEFAULT = 32'h0000_1001;
	// ==========================================================
	// synchroniser depth for pins crossing into clk_i
	localparam int SYNC_STAGES = 3;
endpackage

/* File: verilog/stp_sync.sv */
// three flop synchroniser with agreement filter for one pin level
// assumes the input is asynchronous to clk_i
module stp_sync (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// level in and filtered level out
	input wire logic d_i,
	output logic q_o
);
	import stp_pkg::*;

	// ==========================================================
	// flop chain
	logic [SYNC_STAGES-1:0] chain_q; // first stage read only by second
	logic [SYNC_STAGES-1:0] chain_d;
	logic out_q; // filtered output
	logic out_d;

	// shift and filter: change only when stages two and three agree
	always_comb begin
		chain_d = {chain_q[SYNC_STAGES-2:0], d_i};
		out_d = out_q;
		if (chain_q[1] == chain_q[2]) begin
			out_d = chain_q[2];
		end
	end

	// register stage
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			chain_q <= '0;
			out_q <= 1'b0;
		end else begin
			chain_q <= chain_d;
			out_q <= out_d;
		end
	end

	assign q_o = out_q;
endmodule

/* File: verilog/stp_top.sv */
// scan test port: tap controller on test clock, emulation pins, output disable
// assumes the emulator drives test clock, mode select, data in, test reset
// Function
// - mode select sampled on rising test clock
// - data input captured on rising edge
// - data output changes on falling edge
// - data output floats when disable active
// - test reset low means functional mode
// - line zero is scan-directed emulator interrupt
// - line one: interrupt or disable input
// - disable condition floats every output driver
module stp_top (
	// system clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// test access port, tck is the link clock
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	input wire logic trst_n_i,
	output logic tdo_o,
	output logic tdo_oe_n_o,
	// emulation line zero, three signal pin
	input wire logic emulation_line_zero_i,
	output logic emulation_line_zero_o,
	output logic emulation_line_zero_oe_n_o,
	// emulation line one / disable, three signal pin
	input wire logic emulation_line_one_disable_i,
	output logic emulation_line_one_disable_o,
	output logic emulation_line_one_disable_oe_n_o,
	// core side: emulator interrupts in and out
	input wire logic emu_irq0_req_i,
	input wire logic emu_irq1_req_i,
	output logic emu_irq0_o,
	output logic emu_irq1_o,
	// core side: global output disable and test mode
	output logic outputs_off_o,
	output logic test_mode_o
);
	import stp_pkg::*;

	// ==========================================================
	// tap state, tck domain
	stp_state_e st_q, st_d;
	logic [IR_W-1:0] ir_sh_q, ir_sh_d; // ir shift stage
	logic [IR_W-1:0] ir_q, ir_d; // active instruction
	logic [ID_W-1:0] dr_sh_q, dr_sh_d; // shared data shift stage
	logic [EMU_W-1:0] emu_q, emu_d; // scan-set pin directions
	logic tdo_q; // falling-edge output flop
	logic tdo_en_q; // falling-edge output enable

	// next tap state from mode select
	function automatic stp_state_e tap_next(input stp_state_e s, input logic m);
		case (s)
			ST_RESET: tap_next = m ? ST_RESET : ST_IDLE;
			ST_IDLE: tap_next = m ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: tap_next = m ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: tap_next = m ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: tap_next = m ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_IDLE;
			default: tap_next = ST_RESET;
		endcase
	endfunction

	// ==========================================================
	// tap next-state and register shifting
	always_comb begin
		st_d = tap_next(st_q, tms_i);
		ir_sh_d = ir_sh_q;
		ir_d = ir_q;
		dr_sh_d = dr_sh_q;
		emu_d = emu_q;
		case (st_q)
			ST_RESET: begin
				ir_d = IR_RESET_VAL;
				emu_d = EMU_RESET_VAL;
			end
			ST_CAP_IR: ir_sh_d = {{(IR_W-2){1'b0}}, IR_CAPTURE_VAL};
			ST_SH_IR: ir_sh_d = {tdi_i, ir_sh_q[IR_W-1:1]};
			ST_UPD_IR: ir_d = ir_sh_q;
			ST_CAP_DR: begin
				// capture selected register
				if (ir_q == OP_IDCODE) begin
					dr_sh_d = ID_DEFAULT;
				end else if (ir_q == OP_EMUCTL) begin
					dr_sh_d = {{(ID_W-EMU_W){1'b0}}, emu_q};
				end else begin
					dr_sh_d = '0;
				end
			end
			ST_SH_DR: begin
				// shift length follows the selected register
				if (ir_q == OP_IDCODE) begin
					dr_sh_d = {tdi_i, dr_sh_q[ID_W-1:1]};
				end else if (ir_q == OP_EMUCTL) begin
					dr_sh_d = {{(ID_W-EMU_W){1'b0}}, tdi_i, dr_sh_q[EMU_W-1:1]};
				end else begin
					dr_sh_d = {{(ID_W-1){1'b0}}, tdi_i};
				end
			end
			ST_UPD_DR: begin
				if (ir_q == OP_EMUCTL) begin
					emu_d = dr_sh_q[EMU_W-1:0];
				end
			end
			default: begin
			end
		endcase
	end

	// rising tck registers; trst low holds the tap in reset
	always_ff @(posedge tck_i or negedge trst_n_i) begin
		if (!trst_n_i) begin
			st_q <= ST_RESET;
			ir_sh_q <= '0;
			ir_q <= IR_RESET_VAL;
			dr_sh_q <= '0;
			emu_q <= EMU_RESET_VAL;
		end else begin
			st_q <= st_d;
			ir_sh_q <= ir_sh_d;
			ir_q <= ir_d;
			dr_sh_q <= dr_sh_d;
			emu_q <= emu_d;
		end
	end

	// ==========================================================
	// falling-edge output stage
	logic tdo_d, tdo_en_d;
	always_comb begin
		tdo_en_d = (st_q == ST_SH_DR) || (st_q == ST_SH_IR);
		tdo_d = (st_q == ST_SH_IR) ? ir_sh_q[0] : dr_sh_q[0];
	end

	always_ff @(negedge tck_i or negedge trst_n_i) begin
		if (!trst_n_i) begin
			tdo_q <= 1'b0;
			tdo_en_q <= 1'b0;
		end else begin
			tdo_q <= tdo_d;
			tdo_en_q <= tdo_en_d;
		end
	end

	// ==========================================================
	// pin levels brought into clk_i domain
	logic trst_s, e0_s, e1_s;
	stp_sync u_sync_trst (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(trst_n_i), .q_o(trst_s));
	stp_sync u_sync_e0 (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(emulation_line_zero_i), .q_o(e0_s));
	stp_sync u_sync_e1 (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.d_i(emulation_line_one_disable_i), .q_o(e1_s));
	// scan-set directions are quasi static but still cross as levels
	logic dir0_s, dir1_s;
	stp_sync u_sync_d0 (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(emu_q[0]), .q_o(dir0_s));
	stp_sync u_sync_d1 (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(emu_q[1]), .q_o(dir1_s));

	// ==========================================================
	// clk_i domain: mode, disable, interrupts
	logic off_q, off_d, mode_q, mode_d, irq0_q, irq0_d, irq1_q, irq1_d;
	always_comb begin
		mode_d = trst_s;
		// disable needs trst low, line zero high, line one low
		off_d = !trst_s && e0_s && !e1_s;
		// inputs become interrupts to the core only when not driven out
		irq0_d = trst_s && !dir0_s && e0_s;
		irq1_d = trst_s && !dir1_s && e1_s;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			off_q <= 1'b0;
			mode_q <= 1'b0;
			irq0_q <= 1'b0;
			irq1_q <= 1'b0;
		end else begin
			off_q <= off_d;
			mode_q <= mode_d;
			irq0_q <= irq0_d;
			irq1_q <= irq1_d;
		end
	end

	// ==========================================================
	// pin drive; disable floats tdo and the emulation outputs
	// tdo enable is tck-domain and combined with the async off term directly:
	// floating must not wait for a clock that may be stopped
	logic off_async;
	assign off_async = !trst_n_i && emulation_line_zero_i && !emulation_line_one_disable_i;
	assign tdo_o = tdo_q;
	assign tdo_oe_n_o = !(tdo_en_q && !off_async);
	assign emulation_line_zero_o = emu_irq0_req_i;
	assign emulation_line_zero_oe_n_o = !(trst_n_i && emu_q[0]);
	assign emulation_line_one_disable_o = emu_irq1_req_i;
	assign emulation_line_one_disable_oe_n_o = !(trst_n_i && emu_q[1]);
	assign outputs_off_o = off_q;
	assign test_mode_o = mode_q;
	assign emu_irq0_o = irq0_q;
	assign emu_irq1_o = irq1_q;

	// ==========================================================
	// checks
	AST_TMS_RESET: assert property (@(posedge tck_i) disable iff (!trst_n_i)
		tms_i [*5] |=> st_q == ST_RESET) else $error("five high tms must reach reset");
	AST_TMS_STEP: assert property (@(posedge tck_i) disable iff (!trst_n_i)
		st_q == ST_IDLE && tms_i |=> st_q == ST_SEL_DR) else $error("idle step wrong");
	AST_IR_SHIFT: assert property (@(posedge tck_i) disable iff (!trst_n_i)
		st_q == ST_SH_IR |=> ir_sh_q[IR_W-1] == $past(tdi_i)) else $error("ir shift lost tdi");
	// tdo moves only between rising edges: at each rising edge in data-register shift it must
	// already show the bit about to leave, launched on the falling edge before
	AST_TDO_FALL: assert property (@(posedge tck_i) disable iff (!trst_n_i)
		st_q == ST_SH_DR |-> tdo_en_q && tdo_q == dr_sh_q[0])
		else $error("tdo not settled by falling edge");
	AST_TDO_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		off_async |-> tdo_oe_n_o) else $error("tdo driven while disabled");
	// off and mode are registered from the same synced trst sample
	AST_OFF_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		off_q |-> !mode_q) else $error("disable with trst high");
	AST_MODE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!trst_s [*2] |=> !test_mode_o) else $error("test mode with trst low");
	AST_EMU_FLOAT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!trst_n_i |-> emulation_line_zero_oe_n_o && emulation_line_one_disable_oe_n_o)
		else $error("emulation pin driven in functional mode");
	AST_IRQ1: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		emu_irq1_o |-> !outputs_off_o) else $error("irq and disable together");
	COV_OFF: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(outputs_off_o));
	COV_IR_UPD: cover property (@(posedge tck_i) disable iff (!trst_n_i) st_q == ST_UPD_IR);
	COV_EMU_SET: cover property (@(posedge tck_i) disable iff (!trst_n_i) emu_q == 2'h3);
	COV_IRQ: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(emu_irq0_o));
endmodule

/* File: bench/stp_emu_model.sv */
// emulator-side model: makes the test clock in frames, drives tap inputs and emulation pins
// assumes the bench resolves each pin level from both parties' enables
module stp_emu_model (
	// tap lines toward the device
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o,
	output logic trst_n_o,
	// emulation pin drives, drv high means driving
	output logic emulation_line_zero_drv_o,
	output logic emulation_line_zero_val_o,
	output logic emu1_drv_o,
	output logic emu1_val_o,
	// serial return and its enable
	input wire logic tdo_i,
	input wire logic tdo_oe_n_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// idle levels: clock stands low outside frames, test reset held low
	initial begin
		{tck_o, tms_o, tdi_o, trst_n_o} = 4'h2;
		{emulation_line_zero_drv_o, emulation_line_zero_val_o, emu1_drv_o, emu1_val_o} = 4'h0;
	end
	// one tck period, equal halves of 3 ns; tdo taken after the falling edge
	task automatic step(input logic m, input logic d, output logic q);
		tms_o = m;
		tdi_o = d;
		#1 tck_o = 1'b1;
		#3 tck_o = 1'b0;
		#2 q = tdo_oe_n_i ? 1'bx : tdo_i; // a floating tdo never passes as data
	endtask
	// ==========================================================
	// five ones reach reset whatever the state, then park in idle
	task automatic tap_reset();
		logic q;
		repeat (5) step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask
	// full scan from idle back to idle, lsb first
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic q;
		int i;
		step(1'b1, 1'b0, q);
		if (ir) begin
			step(1'b1, 1'b0, q);
		end
		step(1'b0, 1'b0, q);
		dout = '0;
		step(1'b0, 1'b0, q);
		dout[0] = q;
		for (i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			if (i < n - 1) begin
				dout[i + 1] = q;
			end
		end
		step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask
	task automatic set_trst(input logic v);
		#2 trst_n_o = v;
		#10;
	endtask
	// line zero high and line one low with test reset low requests the disable condition
	task automatic pins(input logic d0, input logic v0, input logic d1, input logic v1);
		{emulation_line_zero_drv_o, emulation_line_zero_val_o, emu1_drv_o, emu1_val_o} = {d0, v0, d1, v1};
	endtask
endmodule

/* File: bench/testbench.sv */
// self-checking bench for the scan test port and emulation pins
// assumes pull-ups on both emulation pins and an emulator model on the tap
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import stp_pkg::*;
	// ==========================================================
	// stimulus and observed nets
	logic clk_i = 1'b0, rst_n_i = 1'b0, irq0_req = 1'b0, irq1_req = 1'b0;
	logic tck, tms, tdi, trst_n, e0_drv, e0_val, e1_drv, e1_val, tdo, tdo_oe_n;
	logic e0_o, e0_oe_n, e1_o, e1_oe_n, irq0_o, irq1_o, off_o, tmode_o, q;
	logic pin0, pin1;
	logic [31:0] rd;
	int err_total = 0, checked = 0, cyc = 0;
	// pin level: device first, then emulator, else pull-up
	assign pin0 = !e0_oe_n ? e0_o : (e0_drv ? e0_val : 1'b1);
	assign pin1 = !e1_oe_n ? e1_o : (e1_drv ? e1_val : 1'b1);
	always #5 clk_i = ~clk_i;
	stp_emu_model emu_u (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n),
		.emulation_line_zero_drv_o(e0_drv), .emulation_line_zero_val_o(e0_val), .emu1_drv_o(e1_drv),
		.emu1_val_o(e1_val), .tdo_i(tdo), .tdo_oe_n_i(tdo_oe_n));
	stp_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
		.trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n),
		.emulation_line_zero_i(pin0), .emulation_line_zero_o(e0_o),
		.emulation_line_zero_oe_n_o(e0_oe_n), .emulation_line_one_disable_i(pin1),
		.emulation_line_one_disable_o(e1_o), .emulation_line_one_disable_oe_n_o(e1_oe_n),
		.emu_irq0_req_i(irq0_req), .emu_irq1_req_i(irq1_req), .emu_irq0_o(irq0_o),
		.emu_irq1_o(irq1_o), .outputs_off_o(off_o), .test_mode_o(tmode_o));
	// ==========================================================
	// comparison, waiting and closing
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// pins cross a three-flop filter, so allow a few system clocks
	task automatic settle();
		repeat (8) @(posedge clk_i);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// hang guard, far above the fewer than two hundred cycles the tests need
	always @(posedge clk_i) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end
	// ==========================================================
	// scenarios
	task automatic t_idcode();
		emu_u.set_trst(1'b1);
		emu_u.tap_reset();
		emu_u.scan(1'b0, ID_W, 32'h0, rd);
		check("id shift", rd, ID_DEFAULT);
		settle();
		check("test mode", tmode_o, 1'b1);
		check("tdo idle enable", tdo_oe_n, 1'b1);
		$display("test idcode done");
	endtask
	task automatic t_bypass();
		emu_u.scan(1'b1, IR_W, OP_BYPASS, rd);
		check("ir capture", rd[3:0], {2'h0, IR_CAPTURE_VAL});
		emu_u.scan(1'b0, 8, 32'hA5, rd);
		check("bypass delay", rd[7:0], 8'h4A);
		// abandon a shift midway, five ones must restore the default instruction
		emu_u.step(1'b1, 1'b0, q);
		emu_u.step(1'b0, 1'b0, q);
		emu_u.step(1'b0, 1'b1, q);
		emu_u.tap_reset();
		emu_u.scan(1'b0, ID_W, 32'h0, rd);
		check("id after abort", rd, ID_DEFAULT);
		$display("test bypass done");
	endtask
	task automatic t_emuctl();
		emu_u.scan(1'b1, IR_W, OP_EMUCTL, rd);
		emu_u.scan(1'b0, EMU_W, 32'h3, rd);
		check("emu capture a", rd[1:0], EMU_RESET_VAL);
		@(posedge clk_i);
		irq0_req <= 1'b1;
		irq1_req <= 1'b0;
		repeat (2) @(posedge clk_i);
		check("line zero out", {e0_oe_n, pin0}, 2'h1);
		check("line one out", {e1_oe_n, pin1}, 2'h0);
		emu_u.scan(1'b0, EMU_W, 32'h0, rd);
		check("emu capture b", rd[1:0], 2'h3);
		emu_u.pins(1'b1, 1'b1, 1'b1, 1'b0);
		settle();
		check("released", {e0_oe_n, e1_oe_n}, 2'h3);
		check("irq in a", {irq0_o, irq1_o}, 2'h2);
		emu_u.pins(1'b1, 1'b0, 1'b1, 1'b1);
		settle();
		check("irq in b", {irq0_o, irq1_o}, 2'h1);
		$display("test emulation control done");
	endtask
	task automatic t_off();
		emu_u.pins(1'b1, 1'b1, 1'b1, 1'b0);
		emu_u.set_trst(1'b0);
		settle();
		check("disable on", {off_o, tmode_o, irq0_o, irq1_o}, 4'h8);
		check("tdo floats", tdo_oe_n, 1'b1);
		check("pins float", {e0_oe_n, e1_oe_n}, 2'h3);
		emu_u.pins(1'b1, 1'b0, 1'b1, 1'b0);
		settle();
		check("zero low", off_o, 1'b0);
		emu_u.pins(1'b0, 1'b0, 1'b0, 1'b0);
		settle();
		check("one pulled up", off_o, 1'b0);
		$display("test output disable done");
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		t_idcode();
		t_bypass();
		t_emuctl();
		t_off();
		summarize();
	end
endmodule
